// ===== src/irq_flags_pkg.sv
// Constants shared by the interrupt indicator block: register offsets,
// field positions, implemented-bit masks and reset values.
// Assumes an 8-bit CPU data path and a 16-bit memory address.
package irq_flags_pkg;

  localparam int          REG_W = 8;
  localparam int          ADR_W = 16;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [15:0] NONMASKABLE_FLAGS_FIRST_OFF   = 16'h1002;
  localparam logic [15:0] NONMASKABLE_ENABLE_SECOND_OFF = 16'h1001;
  localparam logic [15:0] NONMASKABLE_FLAGS_SECOND_OFF  = 16'h1003;
  localparam logic [15:0] NONMASKABLE_CLEAR_FIRST_OFF   = 16'h1004;
  localparam logic [15:0] NONMASKABLE_CLEAR_SECOND_OFF  = 16'h1005;
  localparam logic [15:0] MASKABLE_ENABLE_FIRST_OFF     = 16'h1006;
  localparam logic [15:0] MASKABLE_ENABLE_SECOND_OFF    = 16'h1007;
  localparam logic [15:0] MASKABLE_FLAGS_FIRST_OFF      = 16'h1008;
  localparam logic [15:0] MASKABLE_FLAGS_SECOND_OFF     = 16'h1009;
  localparam logic [15:0] MASKABLE_CLEAR_FIRST_OFF      = 16'h100A;
  localparam logic [15:0] MASKABLE_CLEAR_SECOND_OFF     = 16'h100B;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int          TIMER_LSB     = 4;
  localparam int          WATCHDOG_BIT  = 3;
  localparam int          PORT_LSB      = 0;
  localparam int          TICK_LSB      = 0;
  localparam int          TIME_BASE_LSB = 4;

  // ************************************************************
  // Implemented bits and reset values
  // ************************************************************
  localparam logic [7:0]  NONMASKABLE_FIRST_MASK  = 8'h7F;
  localparam logic [7:0]  NONMASKABLE_SECOND_MASK = 8'h07;
  localparam logic [7:0]  MASKABLE_MASK           = 8'h77;
  localparam logic [7:0]  REG_RESET               = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED           = 8'h00;

endpackage : irq_flags_pkg

// ===== src/flag_bank_if.sv
// Carrier between the register front end and one bank of indicators.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface flag_bank_if;
  import irq_flags_pkg::*;

  logic [REG_W-1:0] set_evt;
  logic [REG_W-1:0] clr_req;
  logic [REG_W-1:0] enable;
  logic [REG_W-1:0] flags;
  logic             request;

  modport bank (input set_evt, input clr_req, input enable, output flags, output request);
  modport ctrl (output set_evt, output clr_req, output enable, input flags, input request);
endinterface : flag_bank_if

// ===== src/flag_bank.sv
// One bank of sticky event indicators with write-one-to-clear and enable gating.
// Assumes event pulses and clear strobes are synchronous to clock_i.
`timescale 1ns/1ps
module flag_bank
  import irq_flags_pkg::*;
#(
  parameter logic [7:0] USED_MASK = 8'hFF
) (
  input  wire logic   clock_i,
  input  wire logic   rst_b_i,
  flag_bank_if.bank   bus
);

  if (USED_MASK == 8'h00) begin : g_bad_mask
    $error("flag_bank: USED_MASK selects no indicator");
  end

  // ************************************************************
  // Per-bit indicators
  // ************************************************************
  // Unused bits are never built, so reserved positions read zero.
  for (genvar i = 0; i < REG_W; i++) begin : g_bit
    if (USED_MASK[i]) begin : g_used
      always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          bus.flags[i] <= 1'b0;
        end else if (bus.set_evt[i]) begin
          bus.flags[i] <= 1'b1;   // Event in the clearing cycle is kept
        end else if (bus.clr_req[i]) begin
          bus.flags[i] <= 1'b0;
        end
      end
    end else begin : g_unused
      assign bus.flags[i] = 1'b0;
    end
  end

  assign bus.request = |(bus.flags & bus.enable);

endmodule // flag_bank

// ===== src/irq_flags.sv
// Interrupt indicator, enable and clear registers for non-maskable and
// maskable sources, with the two request lines to the CPU core.
// Assumes the core drives a synchronous 8-bit memory-mapped register port
// and that event inputs are one-cycle pulses on clock_i.
`timescale 1ns/1ps

// Notes on behaviour
// - The second non-maskable status register shows one-minute, 1 Hz, 2 Hz at bits 2..0, bit 3 zero, reset zero.
// - Writing ones to bits 6..0 of the first non-maskable clear register clears Timer3..1, watchdog, Port3..1.
// - Writing ones to bits 2..0 of the second non-maskable clear register clears one-minute, 1 Hz and 2 Hz.
// - The first maskable enable register holds Timer3..1 enables at bits 6..4, reset zero, bits 7 and 3 zero.
// - The first maskable enable register holds Port3..1 enables at bits 2..0, so 03h enables Port1 and Port2.
// - The second maskable enable register holds 2048, 512 and 64 Hz enables at bits 6..4.
// - The second maskable enable register holds one-minute, 1 Hz, 2 Hz enables at bits 2..0.
// - The first maskable status register shows Timer3..1 at bits 6..4 and Port3..1 at bits 2..0.
// - Writing ones to bits 6..4 and 2..0 of the timer and port clear register clears those maskable indicators.
// - Writing ones to bits 6..4 of the time-base clear register clears the 2048, 512 and 64 Hz indicators.
// - Writing ones to bits 2..0 of the time-base clear register clears one-minute, 1 Hz and 2 Hz indicators.
// - The first non-maskable status register shows Timer3..1, watchdog and Port3..1 at bits 6..0.
// - The second non-maskable enable register gates one-minute, 1 Hz, 2 Hz at bits 2..0.
module irq_flags
  import irq_flags_pkg::*;
(
  input  wire logic                           clock_i,
  input  wire logic                           rst_b_i,
  input  wire logic [irq_flags_pkg::ADR_W-1:0] addr_i,
  input  wire logic [irq_flags_pkg::REG_W-1:0] wdata_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output      logic [irq_flags_pkg::REG_W-1:0] rdata_o,
  input  wire logic [irq_flags_pkg::REG_W-1:0] nonmaskable_enable_first_i,
  input  wire logic [2:0]                     timer_event_i,
  input  wire logic                           watchdog_event_i,
  input  wire logic [2:0]                     port_event_i,
  input  wire logic [2:0]                     tick_event_i,
  input  wire logic [2:0]                     time_base_event_i,
  output      logic                           nmi_req_o,
  output      logic                           int_req_o
);
  import irq_flags_pkg::*;

  // ************************************************************
  // Enable registers
  // ************************************************************
  logic [REG_W-1:0] nonmaskable_enable_second;
  logic [REG_W-1:0] maskable_enable_first;
  logic [REG_W-1:0] maskable_enable_second;
  logic [REG_W-1:0] next_rdata;

  flag_bank_if nmi_first_bus ();
  flag_bank_if nmi_second_bus ();
  flag_bank_if int_first_bus ();
  flag_bank_if int_second_bus ();

  logic wr_nmi_en2;
  logic wr_int_en1;
  logic wr_int_en2;

  assign wr_nmi_en2 = wr_i && (addr_i == NONMASKABLE_ENABLE_SECOND_OFF);
  assign wr_int_en1 = wr_i && (addr_i == MASKABLE_ENABLE_FIRST_OFF);
  assign wr_int_en2 = wr_i && (addr_i == MASKABLE_ENABLE_SECOND_OFF);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nonmaskable_enable_second <= REG_RESET;
    end else if (wr_nmi_en2) begin
      nonmaskable_enable_second <= wdata_i & NONMASKABLE_SECOND_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      maskable_enable_first <= REG_RESET;
    end else if (wr_int_en1) begin
      maskable_enable_first <= wdata_i & MASKABLE_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      maskable_enable_second <= REG_RESET;
    end else if (wr_int_en2) begin
      maskable_enable_second <= wdata_i & MASKABLE_MASK;
    end
  end

  // ************************************************************
  // Event routing and clear strobes
  // ************************************************************
  // Timer, port and tick events feed both a non-maskable and a maskable indicator; the
  // enables only gate the request lines, so software can always poll.
  always_comb begin
    nmi_first_bus.set_evt  = REG_RESET;
    nmi_second_bus.set_evt = REG_RESET;
    int_first_bus.set_evt  = REG_RESET;
    int_second_bus.set_evt = REG_RESET;
    nmi_first_bus.set_evt[TIMER_LSB +: 3]      = timer_event_i;
    nmi_first_bus.set_evt[WATCHDOG_BIT]        = watchdog_event_i;
    nmi_first_bus.set_evt[PORT_LSB +: 3]       = port_event_i;
    nmi_second_bus.set_evt[TICK_LSB +: 3]      = tick_event_i;
    int_first_bus.set_evt[TIMER_LSB +: 3]      = timer_event_i;
    int_first_bus.set_evt[PORT_LSB +: 3]       = port_event_i;
    int_second_bus.set_evt[TIME_BASE_LSB +: 3] = time_base_event_i;
    int_second_bus.set_evt[TICK_LSB +: 3]      = tick_event_i;
  end

  // Only a one clears; a write of zero to any bit leaves the indicator alone
  always_comb begin
    nmi_first_bus.clr_req  = REG_RESET;
    nmi_second_bus.clr_req = REG_RESET;
    int_first_bus.clr_req  = REG_RESET;
    int_second_bus.clr_req = REG_RESET;
    if (wr_i) begin
      if (addr_i == NONMASKABLE_CLEAR_FIRST_OFF) begin
        nmi_first_bus.clr_req = wdata_i & NONMASKABLE_FIRST_MASK;
      end else if (addr_i == NONMASKABLE_CLEAR_SECOND_OFF) begin
        nmi_second_bus.clr_req = wdata_i & NONMASKABLE_SECOND_MASK;
      end else if (addr_i == MASKABLE_CLEAR_FIRST_OFF) begin
        int_first_bus.clr_req = wdata_i & MASKABLE_MASK;
      end else if (addr_i == MASKABLE_CLEAR_SECOND_OFF) begin
        int_second_bus.clr_req = wdata_i & MASKABLE_MASK;
      end
    end
  end

  assign nmi_first_bus.enable  = nonmaskable_enable_first_i & NONMASKABLE_FIRST_MASK;
  assign nmi_second_bus.enable = nonmaskable_enable_second;
  assign int_first_bus.enable  = maskable_enable_first;
  assign int_second_bus.enable = maskable_enable_second;

  // ************************************************************
  // Indicator banks
  // ************************************************************
  flag_bank #(.USED_MASK(NONMASKABLE_FIRST_MASK)) u_nmi_first (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .bus     (nmi_first_bus)
  );

  flag_bank #(.USED_MASK(NONMASKABLE_SECOND_MASK)) u_nmi_second (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .bus     (nmi_second_bus)
  );

  flag_bank #(.USED_MASK(MASKABLE_MASK)) u_int_first (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .bus     (int_first_bus)
  );

  flag_bank #(.USED_MASK(MASKABLE_MASK)) u_int_second (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .bus     (int_second_bus)
  );

  // Level requests: they drop only on a clear, a reset, or a disable by register or by nonmaskable_enable_first_i
  assign nmi_req_o = nmi_first_bus.request || nmi_second_bus.request;
  assign int_req_o = int_first_bus.request || int_second_bus.request;

  // ************************************************************
  // Read port
  // ************************************************************
  // Clear registers are write-only and read as zero like unmapped space.
  always_comb begin
    if (addr_i == NONMASKABLE_FLAGS_FIRST_OFF) begin
      next_rdata = nmi_first_bus.flags;
    end else if (addr_i == NONMASKABLE_ENABLE_SECOND_OFF) begin
      next_rdata = nonmaskable_enable_second;
    end else if (addr_i == NONMASKABLE_FLAGS_SECOND_OFF) begin
      next_rdata = nmi_second_bus.flags;
    end else if (addr_i == MASKABLE_ENABLE_FIRST_OFF) begin
      next_rdata = maskable_enable_first;
    end else if (addr_i == MASKABLE_ENABLE_SECOND_OFF) begin
      next_rdata = maskable_enable_second;
    end else if (addr_i == MASKABLE_FLAGS_FIRST_OFF) begin
      next_rdata = int_first_bus.flags;
    end else if (addr_i == MASKABLE_FLAGS_SECOND_OFF) begin
      next_rdata = int_second_bus.flags;
    end else begin
      next_rdata = READ_UNMAPPED;
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= REG_RESET;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  a_nmi2_status_read: assert property (
    rd_i && addr_i == NONMASKABLE_FLAGS_SECOND_OFF |=>
      rdata_o[7:3] == 5'h00 && rdata_o[2:0] == $past(nmi_second_bus.flags[2:0]))
    else $error("second non-maskable status read wrong");

  a_nmi1_clear_bits: assert property (
    wr_i && addr_i == NONMASKABLE_CLEAR_FIRST_OFF && nmi_first_bus.set_evt == 8'h00 |=>
      (nmi_first_bus.flags & $past(wdata_i)) == 8'h00)
    else $error("first non-maskable clear failed");

  a_nmi2_clear_bits: assert property (
    wr_i && addr_i == NONMASKABLE_CLEAR_SECOND_OFF && tick_event_i == 3'h0 |=>
      (nmi_second_bus.flags & $past(wdata_i)) == 8'h00)
    else $error("second non-maskable clear failed");

  a_int_enable_write: assert property (
    wr_int_en1 |=> maskable_enable_first == ($past(wdata_i) & 8'h77) ##1
      (maskable_enable_first == $past(maskable_enable_first) || $past(wr_int_en1)))
    else $error("first maskable enable not stored");

  a_int2_enable_write: assert property (
    wr_int_en2 |=> maskable_enable_second == ($past(wdata_i) & 8'h77))
    else $error("second maskable enable not stored");

  a_int1_status_read: assert property (
    rd_i && addr_i == MASKABLE_FLAGS_FIRST_OFF |=>
      rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0 && rdata_o == $past(int_first_bus.flags))
    else $error("first maskable status read wrong");

  a_int1_clear_bits: assert property (
    wr_i && addr_i == MASKABLE_CLEAR_FIRST_OFF && int_first_bus.set_evt == 8'h00 |=>
      (int_first_bus.flags & $past(wdata_i)) == 8'h00)
    else $error("timer and port clear failed");

  a_int2_clear_bits: assert property (
    wr_i && addr_i == MASKABLE_CLEAR_SECOND_OFF && int_second_bus.set_evt == 8'h00 |=>
      (int_second_bus.flags & $past(wdata_i)) == 8'h00)
    else $error("time-base clear failed");

  a_nmi2_enable_gate: assert property (
    wr_nmi_en2 && wdata_i == 8'h02 |=> nonmaskable_enable_second == 8'h02 ##0
      (nmi_second_bus.request == nmi_second_bus.flags[1]))
    else $error("second non-maskable enable gating wrong");

  a_event_sets_flag: assert property (
    port_event_i[0] |=> nmi_first_bus.flags[0] && int_first_bus.flags[0])
    else $error("event did not set its indicators");

  a_flag_stays_set: assert property (
    int_second_bus.flags[0] && !int_second_bus.clr_req[0] |=> int_second_bus.flags[0])
    else $error("indicator dropped without a clear");

  a_int_request_level: assert property (
    $rose(int_req_o) |-> $past(int_first_bus.set_evt) != 8'h00 || $past(int_second_bus.set_evt) != 8'h00 ||
      $past(wr_int_en1) || $past(wr_int_en2))
    else $error("maskable request rose without cause");

  a_nmi_request_level: assert property (
    nmi_req_o == ((nmi_first_bus.flags & nonmaskable_enable_first_i) != 8'h00 ||
      (nmi_second_bus.flags & nonmaskable_enable_second) != 8'h00))
    else $error("non-maskable request does not follow indicators and enables");

  a_int1_enable_ports: assert property (
    wr_int_en1 && wdata_i == 8'h03 |=>
      int_first_bus.request == (int_first_bus.flags[0] || int_first_bus.flags[1]))
    else $error("port enables do not gate the maskable request");

  a_int2_enable_tick: assert property (
    wr_int_en2 && wdata_i == 8'h01 |=>
      int_second_bus.request == int_second_bus.flags[0])
    else $error("2 Hz enable does not gate the maskable request");

  a_int2_status_read: assert property (
    rd_i && addr_i == MASKABLE_FLAGS_SECOND_OFF |=>
      rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0 && rdata_o == $past(int_second_bus.flags))
    else $error("second maskable status read wrong");

  a_clear_reads_zero: assert property (
    rd_i && addr_i == NONMASKABLE_CLEAR_SECOND_OFF |=> rdata_o == 8'h00)
    else $error("write-only clear register read non-zero");

  a_zero_write_keeps: assert property (
    wr_i && addr_i == MASKABLE_CLEAR_FIRST_OFF && wdata_i == 8'h00 |=>
      int_first_bus.flags == ($past(int_first_bus.flags) | $past(int_first_bus.set_evt)))
    else $error("writing zero changed an indicator");

  a_tick_sets_both: assert property (
    tick_event_i[2] |=> nmi_second_bus.flags[2] && int_second_bus.flags[2])
    else $error("one-minute event did not set its indicators");

  a_timer_sets_both: assert property (
    timer_event_i[2] |=> nmi_first_bus.flags[6] && int_first_bus.flags[6])
    else $error("timer event did not set its indicators");

  a_time_base_sets: assert property (
    time_base_event_i[0] |=> int_second_bus.flags[4])
    else $error("64 Hz event did not set its indicator");

  c_set_beats_clear: cover property (
    wr_i && addr_i == MASKABLE_CLEAR_SECOND_OFF && wdata_i[0] && tick_event_i[0] ##1 int_second_bus.flags[0]);
  c_nmi_request: cover property ($rose(nmi_req_o));
  c_int_request_drop: cover property (int_req_o ##1 !int_req_o);
  c_both_requests: cover property (nmi_req_o && int_req_o);

endmodule // irq_flags

// ===== tb/cpu_port_model.sv
// CPU core model: issues single-byte register writes and reads.
// Assumes a one-cycle strobe and read data one cycle after the read edge.
`timescale 1ns/1ps
module cpu_port_model (
  input  wire logic        clock_i,
  output logic [15:0]      addr_o,
  output logic [7:0]       wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [7:0]  rdata_i
);
  initial begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i) #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clock_i) #1;
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask

  task automatic read_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clock_i) #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clock_i) #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
endmodule // cpu_port_model

// ===== tb/testbench.sv
// Self-checking bench for the interrupt indicator block.
// Assumes the CPU model drives the register port and this module drives events.
`timescale 1ns/1ps
module testbench;
  import irq_flags_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  nm_en1 = 8'h00;
  logic [2:0]  tmr = 3'h0;
  logic        wdg = 1'b0;
  logic [2:0]  prt = 3'h0;
  logic [2:0]  tck = 3'h0;
  logic [2:0]  tbs = 3'h0;
  logic        nmi_req;
  logic        int_req;
  logic [7:0]  f_nm1 = 8'h00;
  logic [7:0]  f_nm2 = 8'h00;
  logic [7:0]  f_m1 = 8'h00;
  logic [7:0]  f_m2 = 8'h00;
  logic [7:0]  e_nm2 = 8'h00;
  logic [7:0]  e_m1 = 8'h00;
  logic [7:0]  e_m2 = 8'h00;
  int          n_fail = 0;
  int          comparisons = 0;

  always #2.5 clock_i = ~clock_i;

  cpu_port_model u_cpu (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
                        .rdata_i(rdata));
  irq_flags u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
                   .rd_i(rd), .rdata_o(rdata), .nonmaskable_enable_first_i(nm_en1), .timer_event_i(tmr),
                   .watchdog_event_i(wdg), .port_event_i(prt), .tick_event_i(tck),
                   .time_base_event_i(tbs), .nmi_req_o(nmi_req), .int_req_o(int_req));

  // ************************************************************
  // Expectations and checks
  // ************************************************************
  function automatic logic exp_nmi();
    return |(f_nm1 & nm_en1 & 8'h7F) | |(f_nm2 & e_nm2);
  endfunction

  function automatic logic exp_int();
    return |(f_m1 & e_m1) | |(f_m2 & e_m2);
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_cpu.read_reg(a, d);
    chk(d, exp, "register read");
  endtask

  task automatic check_all();
    rd_chk(16'h1002, f_nm1);
    rd_chk(16'h1003, f_nm2);
    rd_chk(16'h1008, f_m1);
    rd_chk(16'h1009, f_m2);
    chk({7'h00, nmi_req}, {7'h00, exp_nmi()}, "nmi request");
    chk({7'h00, int_req}, {7'h00, exp_int()}, "int request");
  endtask

  task automatic en(input logic [15:0] a, input logic [7:0] d);
    u_cpu.write_reg(a, d);
    if (a == 16'h1001) e_nm2 = d & 8'h07;
    if (a == 16'h1006) e_m1 = d & 8'h77;
    if (a == 16'h1007) e_m2 = d & 8'h77;
  endtask

  task automatic clr(input logic [15:0] a, input logic [7:0] d);
    en(a, d);
    if (a == 16'h1004) f_nm1 &= ~(d & 8'h7F);
    if (a == 16'h1005) f_nm2 &= ~(d & 8'h07);
    if (a == 16'h100A) f_m1 &= ~(d & 8'h77);
    if (a == 16'h100B) f_m2 &= ~(d & 8'h77);
  endtask

  task automatic pulse(input logic [12:0] v);
    @(posedge clock_i) #1;
    {tmr, wdg, prt, tck, tbs} = v;
    f_nm1 |= {1'b0, v[12:6]};
    f_nm2 |= {5'h00, v[5:3]};
    f_m1 |= {1'b0, v[12:10], 1'b0, v[8:6]};
    f_m2 |= {1'b0, v[2:0], 1'b0, v[5:3]};
    @(posedge clock_i) #1;
    {tmr, wdg, prt, tck, tbs} = 13'h0000;
  endtask

  task automatic stop_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    logic [15:0] ca;
    void'($urandom(32'hDFD9BCED));
    repeat (12) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    for (int a = 16'h1000; a <= 16'h100C; a++) rd_chk(a[15:0], 8'h00);
    en(16'h1006, 8'h03);
    rd_chk(16'h1006, 8'h03);
    en(16'h1007, 8'h01);
    rd_chk(16'h1007, 8'h01);
    en(16'h1001, 8'h02);
    rd_chk(16'h1001, 8'h02);
    en(16'h1006, 8'hFF);
    rd_chk(16'h1006, 8'h77);
    en(16'h1007, 8'hFF);
    rd_chk(16'h1007, 8'h77);
    // Status registers must ignore writes
    u_cpu.write_reg(16'h1008, 8'hFF);
    u_cpu.write_reg(16'h1003, 8'hFF);
    check_all();
    pulse(13'h1FFF);
    check_all();
    for (int a = 16'h1004; a <= 16'h100B; a++) clr(a[15:0], 8'h00);
    check_all();
    clr(16'h100A, 8'h77);
    check_all();
    clr(16'h100B, 8'h01);
    check_all();
    clr(16'h1004, 8'h7F);
    clr(16'h1005, 8'h01);
    check_all();
    clr(16'h100B, 8'h70);
    check_all();
    // Event and clear of one indicator in one cycle: the event wins
    fork
      clr(16'h100B, 8'h01);
      pulse(13'h0008);
    join
    f_m2[0] = 1'b1;
    check_all();
    // Reset in mid-run returns every register to zero
    @(posedge clock_i) #1;
    rst_b_i = 1'b0;
    {f_nm1, f_nm2, f_m1, f_m2, e_nm2, e_m1, e_m2} = 56'h0;
    repeat (2) @(posedge clock_i);
    #1 rst_b_i = 1'b1;
    check_all();
    repeat (150) begin
      @(posedge clock_i) #1;
      nm_en1 = 8'($urandom);
      en(16'h1001, 8'($urandom));
      en(16'h1006, 8'($urandom));
      en(16'h1007, 8'($urandom));
      pulse(13'($urandom));
      ca = 16'h1004 + 16'($urandom_range(1));
      if ($urandom_range(1)) ca = 16'h100A + 16'($urandom_range(1));
      clr(ca, 8'($urandom));
      check_all();
    end
    stop_test();
  end

  initial begin
    #(5 * 40000);
    n_fail++;
    stop_test();
  end
endmodule // testbench
